// ### core/dual_channel_register_access.v
// host register access and address decoding for a two channel serial controller
`timescale 1ns/1ns
`include "dual_access_map.vh"

// Overview of operation
// RULE_01: data select high routes access to data
// RULE_02: other registers take two accesses via pointer
// RULE_03: pointed register takes the next access
// RULE_04: pointer clears itself after the second access
// RULE_05: channel b command picks address decode mode
// RULE_06: low bit mode: channel from bit 0
// RULE_07: high bit mode: channel from bit 5
// RULE_08: register number always from bits 4..1
// RULE_09: address latched on strobe rising edge
// RULE_10: reset selects high bit decode mode
// RULE_11: decode mode changes only by its command
// RULE_12: one vector, one control, either channel
// RULE_13: shared registers hold vector, control, resets
// RULE_14: register seven goes to extension when enabled
// RULE_15: sixteen write registers per channel plus data
// RULE_16: incomplete read decode aliases with fifo off
// RULE_17: low bit mode interleaves channel b and a
// RULE_18: host programs mode, settings, interrupts, enables
// RULE_19: pointer bits 2..0, point high adds eight
// RULE_20: status fifo enable unmasks reads 6, 7
// RULE_21: extended read returns write register images
// RULE_22: any reset clears the register pointer
// RULE_23: every register is eight bits wide
module dual_channel_register_access #(
   parameter MUX_BUS = 1'b0
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // host bus strobes, active low
   input wire cs_n,
   input wire rd_n,
   input wire wr_n,
   // pointer-addressed variant selects
   input wire chan_a_sel,
   input wire fifo_or_command_select,
   // multiplexed variant address strobe
   input wire address_latch_strobe,
   // data bus, multiplexed_bus on the multiplexed variant
   input wire [7:0] data_in,
   output reg [7:0] data_out,
   output wire data_oe,
   // channel read register sources
   input wire [127:0] status_a,
   input wire [127:0] status_b,
   // write register images
   output wire [127:0] wr_regs_a,
   output wire [127:0] wr_regs_b,
   output wire [7:0] ext_a,
   output wire [7:0] ext_b,
   output wire [7:0] shared_vector_reg,
   output wire [7:0] shared_interrupt_control_reg,
   output wire channel_in_high_bit,
   // data path strobes
   output reg tx_wr_a,
   output reg tx_wr_b,
   output reg [7:0] tx_data,
   output reg rx_rd_a,
   output reg rx_rd_b
);

// ------------------------------------------------
// declarations
// ------------------------------------------------
reg [13:0] sync1_r;
reg [13:0] sync2_r;
reg rd_d_r;
reg wr_d_r;
reg als_d_r;
reg rd_act_r;
reg wr_act_r;
reg [7:0] adr_r;
reg [7:0] wdata_r;
reg [3:0] ptr_r;
reg [3:0] ptr_nxt;
reg mode_high_r;
reg [7:0] vec_r;
reg [7:0] ictl_r;
reg force_rst_r;
reg [1:0] clr_r;
reg acc_chan_r;
reg [3:0] acc_reg_r;
reg acc_ptr_r;
reg cur_chan;
reg [3:0] cur_reg;
reg [7:0] rd_val;
wire [7:0] din;
wire cs_q;
wire rd_q;
wire wr_q;
wire chan_pin;
wire fifo_pin;
wire als_q;
wire rd_start;
wire rd_end;
wire wr_start;
wire wr_end;
wire als_rise;
wire soft_rst;
wire bank_we;
wire [4:0] rd_src;
wire [127:0] bank_img [0:1];
wire [7:0] bank_ext [0:1];
wire [1:0] bank_fifo;
wire [127:0] st_cur;
wire [127:0] wr_cur;
wire [7:0] ext_cur;
wire [1:0] rst_code;

// ------------------------------------------------
// helpers
// ------------------------------------------------
function is_banked;
   input [3:0] r;
   begin
      is_banked = (r != `REG_CMD) && (r != `REG_VECTOR) &&
                  (r != `REG_DATA) && (r != `REG_INTCTL);
   end
endfunction

// ------------------------------------------------
// pin synchronisers
// ------------------------------------------------
// every pin, data included, is two flops late; host timing must cover it
always @(posedge clk)
begin
   if (!rst_n)
   begin
      sync1_r <= `SYNC_IDLE;
      sync2_r <= `SYNC_IDLE;
   end
   else
   begin
      sync1_r <= {address_latch_strobe, fifo_or_command_select, chan_a_sel,
                  wr_n, rd_n, cs_n, data_in};
      sync2_r <= sync1_r;
   end
end

assign din = sync2_r[7:0];
assign cs_q = ~sync2_r[8];
assign rd_q = ~sync2_r[9];
assign wr_q = ~sync2_r[10];
assign chan_pin = sync2_r[11];
assign fifo_pin = sync2_r[12];
assign als_q = sync2_r[13];

assign rd_start = rd_q & ~rd_d_r & cs_q;
assign rd_end = ~rd_q & rd_d_r & rd_act_r;
assign wr_start = wr_q & ~wr_d_r & cs_q;
assign wr_end = ~wr_q & wr_d_r & wr_act_r;
assign als_rise = als_q & ~als_d_r;

// ------------------------------------------------
// current address decode
// ------------------------------------------------
always @*
begin
   cur_chan = chan_pin;
   cur_reg = ptr_r; // RULE_02 RULE_03
   if (MUX_BUS)
   begin
      cur_reg = adr_r[`ADR_REG_MSB:`ADR_REG_LSB]; // RULE_08
      if (mode_high_r)
         cur_chan = adr_r[`ADR_CHAN_HI]; // RULE_07
      else
         cur_chan = adr_r[`ADR_CHAN_LO]; // RULE_06 RULE_17
   end
   else if (fifo_pin)
   begin
      cur_reg = `REG_DATA; // RULE_01
   end
end

// ------------------------------------------------
// read source selection
// ------------------------------------------------
assign st_cur = cur_chan ? status_a : status_b;
assign wr_cur = cur_chan ? wr_regs_a : wr_regs_b;
assign ext_cur = cur_chan ? ext_a : ext_b;

read_source_decode u_rd_dec (
   .reg_num (cur_reg),
   .fifo_en (bank_fifo[cur_chan]),
   .ext_rd (ext_cur[`EXT_READ_BIT]),
   .src (rd_src)
);

always @*
begin
   rd_val = st_cur[{rd_src[3:0], 3'b000} +: 8];
   if (rd_src[4])
   begin
      if (rd_src[3:0] == `REG_CMD)
         rd_val = ext_cur; // RULE_21
      else
         rd_val = wr_cur[{rd_src[3:0], 3'b000} +: 8]; // RULE_21
   end
end

// ------------------------------------------------
// channel write banks, index 1 is channel a
// ------------------------------------------------
assign bank_we = wr_end && is_banked(acc_reg_r);

genvar c;
generate
   for (c = 0; c < 2; c = c + 1)
   begin : bank
      channel_write_bank u_bank (
         .clk (clk),
         .rst_n (rst_n),
         .clr (force_rst_r | clr_r[c]),
         .we (bank_we && (acc_chan_r == c)),
         .addr (acc_reg_r),
         .wdata (wdata_r),
         .regs_flat (bank_img[c]),
         .ext_r (bank_ext[c]),
         .fifo_en (bank_fifo[c])
      );
   end
endgenerate

assign wr_regs_a = bank_img[1];
assign wr_regs_b = bank_img[0];
assign ext_a = bank_ext[1];
assign ext_b = bank_ext[0];

// ------------------------------------------------
// reset commands
// ------------------------------------------------
assign soft_rst = wr_end && (acc_reg_r == `REG_INTCTL);
assign rst_code = wdata_r[`ICTL_RST_MSB:`ICTL_RST_LSB];

always @(posedge clk)
begin
   if (!rst_n)
   begin
      force_rst_r <= 1'b0;
      clr_r <= 2'b00;
   end
   else
   begin
      force_rst_r <= soft_rst && (rst_code == `RST_FORCE); // RULE_13
      clr_r[1] <= soft_rst && (rst_code == `RST_CHAN_A); // RULE_13
      clr_r[0] <= soft_rst && (rst_code == `RST_CHAN_B); // RULE_13
   end
end

// ------------------------------------------------
// register pointer
// ------------------------------------------------
always @*
begin
   ptr_nxt = ptr_r;
   if (!MUX_BUS && wr_end && !acc_ptr_r && (acc_reg_r == `REG_CMD))
   begin
      ptr_nxt = {(wdata_r[`CMD_MSB:`CMD_LSB] == `CMD_POINT_HIGH),
                 wdata_r[`PTR_MSB:0]}; // RULE_19 RULE_03
   end
   else if ((wr_end || rd_end) && acc_ptr_r)
   begin
      ptr_nxt = `PTR_RESET; // RULE_04
   end
end

// ------------------------------------------------
// host access sequencing
// ------------------------------------------------
// a force reset clears the pointer too, so the next access hits the command register
always @(posedge clk)
begin
   if (!rst_n || force_rst_r)
   begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
      als_d_r <= 1'b0;
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
      adr_r <= `REG_RESET;
      wdata_r <= `REG_RESET;
      ptr_r <= `PTR_RESET; // RULE_22
      mode_high_r <= 1'b1; // RULE_10
      vec_r <= `REG_RESET;
      ictl_r <= `REG_RESET;
      acc_chan_r <= 1'b0;
      acc_reg_r <= `REG_CMD;
      acc_ptr_r <= 1'b0;
      data_out <= `REG_RESET;
      tx_data <= `REG_RESET;
      tx_wr_a <= 1'b0;
      tx_wr_b <= 1'b0;
      rx_rd_a <= 1'b0;
      rx_rd_b <= 1'b0;
   end
   else
   begin
      rd_d_r <= rd_q;
      wr_d_r <= wr_q;
      als_d_r <= als_q;
      ptr_r <= ptr_nxt;
      if (als_rise)
         adr_r <= din; // RULE_09
      // data taken while the strobe is still low, so release skew cannot bite
      if (wr_q)
         wdata_r <= din;
      if (rd_start || wr_start)
      begin
         acc_chan_r <= cur_chan;
         acc_reg_r <= cur_reg;
         acc_ptr_r <= !MUX_BUS && !fifo_pin && (ptr_r != `PTR_RESET); // RULE_02
      end
      if (rd_start)
      begin
         rd_act_r <= 1'b1;
         data_out <= rd_val; // value held stable for the whole read
      end
      else if (rd_end)
      begin
         rd_act_r <= 1'b0;
      end
      if (wr_start)
         wr_act_r <= 1'b1;
      else if (wr_end)
         wr_act_r <= 1'b0;
      tx_wr_a <= wr_end && (acc_reg_r == `REG_DATA) && acc_chan_r; // RULE_15
      tx_wr_b <= wr_end && (acc_reg_r == `REG_DATA) && !acc_chan_r; // RULE_15
      rx_rd_a <= rd_end && (acc_reg_r == `REG_DATA) && acc_chan_r;
      rx_rd_b <= rd_end && (acc_reg_r == `REG_DATA) && !acc_chan_r;
      if (wr_end && (acc_reg_r == `REG_DATA))
         tx_data <= wdata_r;
      if (wr_end && (acc_reg_r == `REG_VECTOR))
         vec_r <= wdata_r; // RULE_12 RULE_13
      if (soft_rst)
         ictl_r <= {2'b00, wdata_r[`ICTL_RST_LSB-1:0]}; // RULE_12 RULE_13
      if (MUX_BUS && wr_end && (acc_reg_r == `REG_CMD) && !acc_chan_r)
      begin
         case (wdata_r[`SHIFT_MSB:0])
            `SHIFT_CMD_LEFT:
               mode_high_r <= 1'b1; // RULE_05 RULE_11
            `SHIFT_CMD_RIGHT:
               mode_high_r <= 1'b0; // RULE_05 RULE_11
            default:
               mode_high_r <= mode_high_r;
         endcase
      end
   end
end

// ------------------------------------------------
// outputs
// ------------------------------------------------
assign data_oe = rd_act_r;
assign shared_vector_reg = vec_r;
assign shared_interrupt_control_reg = ictl_r;
assign channel_in_high_bit = mode_high_r;

endmodule

// ### core/dual_access_map.vh
// register offsets, fields and reset values for the dual channel register access block
`ifndef DUAL_ACCESS_MAP_VH
`define DUAL_ACCESS_MAP_VH
// ------------------------------------------------
// register numbers within a channel
// ------------------------------------------------
`define REG_CMD 4'h0
`define REG_RR1 4'h1
`define REG_VECTOR 4'h2
`define REG_WR3 4'h3
`define REG_WR4 4'h4
`define REG_WR5 4'h5
`define REG_RR6 4'h6
`define REG_WR7 4'h7
`define REG_DATA 4'h8
`define REG_INTCTL 4'h9
`define REG_WR10 4'ha
`define REG_RR11 4'hb
`define REG_RR13 4'hd
`define REG_RR14 4'he
`define REG_XCTL 4'hf
// ------------------------------------------------
// field positions
// ------------------------------------------------
`define XCTL_EXT_WR_BIT 0
`define XCTL_FIFO_BIT 2
`define EXT_READ_BIT 6
`define PTR_MSB 2
`define CMD_MSB 5
`define CMD_LSB 3
`define SHIFT_MSB 1
`define ICTL_RST_MSB 7
`define ICTL_RST_LSB 6
`define ADR_CHAN_HI 5
`define ADR_CHAN_LO 0
`define ADR_REG_MSB 4
`define ADR_REG_LSB 1
// ------------------------------------------------
// command codes
// ------------------------------------------------
`define CMD_POINT_HIGH 3'h1
`define SHIFT_CMD_LEFT 2'h1
`define SHIFT_CMD_RIGHT 2'h2
`define RST_CHAN_B 2'h1
`define RST_CHAN_A 2'h2
`define RST_FORCE 2'h3
// ------------------------------------------------
// reset values and read sources
// ------------------------------------------------
`define REG_RESET 8'h00
`define PTR_RESET 4'h0
`define SYNC_IDLE 14'h0700
`define SRC_EXT 5'h10
`endif

// ### core/read_source_decode.v
// read address to read source decoder for one channel
`timescale 1ns/1ns
`include "dual_access_map.vh"

module read_source_decode (
   // request
   input wire [3:0] reg_num,
   input wire fifo_en,
   input wire ext_rd,
   // source: bit 4 set selects a write register image
   output reg [4:0] src
);

wire ext_on;

assign ext_on = fifo_en & ext_rd;

always @*
begin
   src = {1'b0, reg_num};
   case (reg_num)
      `REG_WR4:
         src = ext_on ? {1'b1, `REG_WR4} : {1'b0, `REG_CMD}; // RULE_16 RULE_21
      `REG_WR5:
         src = ext_on ? {1'b1, `REG_WR5} : {1'b0, `REG_RR1}; // RULE_16 RULE_21
      `REG_RR6:
         src = fifo_en ? {1'b0, `REG_RR6} : {1'b0, `REG_VECTOR}; // RULE_16 RULE_20
      `REG_WR7:
         src = fifo_en ? {1'b0, `REG_WR7} : {1'b0, `REG_WR3}; // RULE_16 RULE_20
      `REG_INTCTL:
         src = ext_on ? {1'b1, `REG_WR3} : {1'b0, `REG_RR13}; // RULE_16 RULE_21
      `REG_RR11:
         src = ext_on ? {1'b1, `REG_WR10} : {1'b0, `REG_XCTL}; // RULE_16 RULE_21
      `REG_RR14:
         src = ext_on ? `SRC_EXT : {1'b0, `REG_RR14}; // RULE_21
      default:
         src = {1'b0, reg_num};
   endcase
end

endmodule

// ### core/channel_write_bank.v
// write register bank of one channel with its extension register
`timescale 1ns/1ns
`include "dual_access_map.vh"

module channel_write_bank (
   // clock and reset
   input wire clk,
   input wire rst_n,
   input wire clr,
   // write port
   input wire we,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   // register images
   output wire [127:0] regs_flat,
   output reg [7:0] ext_r,
   output wire fifo_en
);

reg [7:0] mem_r [0:15];
wire ext_sel;
integer i;
genvar g;

// ------------------------------------------------
// storage
// ------------------------------------------------
assign ext_sel = (addr == `REG_WR7) && mem_r[`REG_XCTL][`XCTL_EXT_WR_BIT];

always @(posedge clk)
begin
   if (!rst_n || clr)
   begin
      for (i = 0; i < 16; i = i + 1)
         mem_r[i] <= `REG_RESET;
      ext_r <= `REG_RESET;
   end
   else if (we)
   begin
      if (ext_sel)
         ext_r <= wdata; // RULE_14
      else
         mem_r[addr] <= wdata; // RULE_15 RULE_23
   end
end

generate
   for (g = 0; g < 16; g = g + 1)
   begin : img
      assign regs_flat[g*8 +: 8] = mem_r[g];
   end
endgenerate

assign fifo_en = mem_r[`REG_XCTL][`XCTL_FIFO_BIT]; // RULE_20

endmodule

// ### test/bus_host.sv
// host processor model for the multiplexed register bus
`timescale 1ns/1ns
module bus_host (
   // clock
   input wire clk,
   // strobes
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic address_latch_strobe,
   // multiplexed bus
   output logic [7:0] data_in,
   input wire [7:0] data_out,
   input wire data_oe
);
   // ------------------------------------------------
   // bus cycles, all changes at the falling edge
   // ------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // address held three clocks after the strobe rises
   task automatic addr_phase(input logic [7:0] a);
      data_in = a;
      cs_n = 1'b0;
      cyc(1);
      address_latch_strobe = 1'b1;
      cyc(3);
   endtask
   // released bus shows the inverse, never a stale value
   task automatic end_cycle();
      cyc(5);
      cs_n = 1'b1;
      address_latch_strobe = 1'b0;
      data_in = ~data_in;
      cyc(3);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_phase(a);
      data_in = d;
      wr_n = 1'b0;
      cyc(3);
      wr_n = 1'b1;
      end_cycle();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      addr_phase(a);
      data_in = ~a;
      rd_n = 1'b0;
      cyc(4);
      // an undriven bus reads back as junk
      d = data_oe ? data_out : ~data_out;
      cyc(1);
      rd_n = 1'b1;
      end_cycle();
   endtask
   initial
   begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      address_latch_strobe = 1'b0;
      data_in = 8'hff;
   end
endmodule

// ### test/access_asserts.sv
// port checks for the dual channel register access block
`timescale 1ns/1ns
module access_asserts (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // host bus
   input wire cs_n,
   input wire rd_n,
   input wire wr_n,
   input wire [7:0] data_out,
   input wire data_oe,
   // images
   input wire [127:0] wr_regs_a,
   input wire [127:0] wr_regs_b,
   input wire [7:0] shared_vector_reg,
   input wire channel_in_high_bit,
   // strobes
   input wire tx_wr_a,
   input wire tx_wr_b,
   input wire rx_rd_a,
   input wire rx_rd_b
);
   // ------------------------------------------------
   // cycles since the write strobe was low
   // ------------------------------------------------
   logic [3:0] since_wr_r;
   always @(posedge clk)
   begin
      if (!rst_n || !wr_n)
         since_wr_r <= 4'h0;
      else if (since_wr_r != 4'hf)
         since_wr_r <= since_wr_r + 4'h1;
   end
   // ------------------------------------------------
   // properties
   // ------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence read_start;
      $fell(rd_n) && !cs_n;
   endsequence
   sequence quiet_host;
      cs_n [*8];
   endsequence
   a_read_drives_bus: assert property (read_start |-> ##[1:4] data_oe)
      else $error("read did not drive the bus");
   a_idle_no_drive: assert property (quiet_host |-> !data_oe && !tx_wr_a && !tx_wr_b)
      else $error("activity without chip select");
   a_oe_holds: assert property ($rose(data_oe) |=> data_oe)
      else $error("read data dropped early");
   a_data_held: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
      else $error("read data changed while driven");
   a_tx_one_cycle: assert property (tx_wr_a || tx_wr_b |=> !tx_wr_a && !tx_wr_b)
      else $error("data write pulse too long");
   a_rx_one_cycle: assert property (rx_rd_a || rx_rd_b |=> !rx_rd_a && !rx_rd_b)
      else $error("data read pulse too long");
   a_tx_after_write: assert property (tx_wr_a || tx_wr_b |->
      since_wr_r >= 4'h1 && since_wr_r <= 4'h8)
      else $error("data write pulse without a write");
   a_mode_by_write: assert property ($changed(channel_in_high_bit) |->
      since_wr_r >= 4'h1 && since_wr_r <= 4'h8)
      else $error("decode mode changed without a write");
   a_reset_state: assert property ($rose(rst_n) |-> channel_in_high_bit &&
      !data_oe && wr_regs_a == 128'h0 && wr_regs_b == 128'h0 && shared_vector_reg == 8'h00)
      else $error("wrong state after reset");
   a_no_drive_write: assert property (!(data_oe && !wr_n))
      else $error("bus driven during a write");
endmodule
bind dual_channel_register_access access_asserts u_access_asserts (
   .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
   .data_out(data_out), .data_oe(data_oe), .wr_regs_a(wr_regs_a), .wr_regs_b(wr_regs_b),
   .shared_vector_reg(shared_vector_reg), .channel_in_high_bit(channel_in_high_bit),
   .tx_wr_a(tx_wr_a), .tx_wr_b(tx_wr_b), .rx_rd_a(rx_rd_a), .rx_rd_b(rx_rd_b)
);

// ### test/dual_channel_register_access_tb.sv
// self-checking bench for the dual channel register access block
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; $display("Error at %0t: got %h, expected %h", $time, got, exp); end end
module dual_channel_register_access_tb;
   // ------------------------------------------------
   // signals
   // ------------------------------------------------
   typedef struct packed {logic a; logic [3:0] r; logic [7:0] d;} row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mode_hi = 1'b1;
   logic [127:0] st_a = 128'hafae_adac_abaa_a9a8_a7a6_a5a4_a3a2_a1a0;
   logic [127:0] st_b = 128'hbfbe_bdbc_bbba_b9b8_b7b6_b5b4_b3b2_b1b0;
   logic [8:0] tx_seen = 9'h000;
   int rx_seen = 0;
   int bad_count = 0;
   int n_checks = 0;
   wire cs_n, rd_n, wr_n, als, oe, hi, txa, txb, rxa, rxb;
   wire [7:0] din, dout, ext_a, ext_b, vec, ictl, txd;
   wire [127:0] wr_a, wr_b;
   wire cs2_n, rd2_n, wr2_n, als2, oe2;
   wire [7:0] din2, dout2, txd2;
   wire [127:0] wr_a2, wr_b2;
   logic chan_sel = 1'b0;
   logic fifo_sel = 1'b0;
   // write rows: channel a, register, data
   row_t wrows [19] = '{13'h1111, 13'h0121, 13'h1313, 13'h0323, 13'h0424, 13'h1515,
      13'h0525, 13'h1616, 13'h0a2a, 13'h1b1b, 13'h0c2c, 13'h1d1d, 13'h0e2e, 13'h1717,
      13'h1292, 13'h0293, 13'h0905, 13'h1906, 13'h0f05};
   // read rows: a with status fifo off, b with fifo and extended read on
   row_t rrows [18] = '{13'h14a0, 13'h15a1, 13'h16a2, 13'h17a3, 13'h19ad, 13'h1baf,
      13'h11a1, 13'h1dad, 13'h10a0, 13'h0424, 13'h0525, 13'h0923, 13'h0b2a, 13'h0e40,
      13'h06b6, 13'h07b7, 13'h00b0, 13'h0cbc};
   dual_channel_register_access #(.MUX_BUS(1'b1)) DUT (
      .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .chan_a_sel(1'b0), .fifo_or_command_select(1'b0), .address_latch_strobe(als),
      .data_in(din), .data_out(dout), .data_oe(oe), .status_a(st_a), .status_b(st_b),
      .wr_regs_a(wr_a), .wr_regs_b(wr_b), .ext_a(ext_a), .ext_b(ext_b),
      .shared_vector_reg(vec), .shared_interrupt_control_reg(ictl),
      .channel_in_high_bit(hi), .tx_wr_a(txa), .tx_wr_b(txb), .tx_data(txd),
      .rx_rd_a(rxa), .rx_rd_b(rxb)
   );
   bus_host host (
      .clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .address_latch_strobe(als),
      .data_in(din), .data_out(dout), .data_oe(oe)
   );
   // pointer variant: the address phase of the host is simply ignored there
   dual_channel_register_access #(.MUX_BUS(1'b0)) DUT_PTR (
      .clk(clk), .rst_n(rst_n), .cs_n(cs2_n), .rd_n(rd2_n), .wr_n(wr2_n),
      .chan_a_sel(chan_sel), .fifo_or_command_select(fifo_sel), .address_latch_strobe(als2),
      .data_in(din2), .data_out(dout2), .data_oe(oe2), .status_a(st_a), .status_b(st_b),
      .wr_regs_a(wr_a2), .wr_regs_b(wr_b2), .ext_a(), .ext_b(), .shared_vector_reg(),
      .shared_interrupt_control_reg(), .channel_in_high_bit(), .tx_wr_a(), .tx_wr_b(),
      .tx_data(txd2), .rx_rd_a(), .rx_rd_b()
   );
   bus_host host2 (
      .clk(clk), .cs_n(cs2_n), .rd_n(rd2_n), .wr_n(wr2_n), .address_latch_strobe(als2),
      .data_in(din2), .data_out(dout2), .data_oe(oe2)
   );
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   // ignored address bits carry ones so a decode slip shows
   function automatic logic [7:0] adr(input logic a, input logic [3:0] r);
      return mode_hi ? {2'b11, a, r, 1'b1} : {2'b11, 1'b1, r, a};
   endfunction
   function automatic logic [7:0] img(input logic a, input logic [3:0] r);
      if (r == 4'h2)
         return vec;
      if (r == 4'h9)
         return ictl;
      return a ? wr_a[8*r +: 8] : wr_b[8*r +: 8];
   endfunction
   task automatic conclude();
      $display("checks %0d, errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      if (txa)
         tx_seen <= {1'b1, txd};
      if (rxa)
         rx_seen <= rx_seen + 1;
   end
   initial
   begin
      forever #50 clk = ~clk;
   end
   initial
   begin
      #1000000;
      bad_count++;
      conclude();
   end
   // ------------------------------------------------
   // tests
   // ------------------------------------------------
   initial
   begin
      logic [7:0] got;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      `CHK({hi, vec}, 9'h100)
      repeat (10) @(negedge clk);
      // settings first, then reads, decode mode, data path and reset commands
      foreach (wrows[i])
      begin
         host.wr(adr(wrows[i].a, wrows[i].r), wrows[i].d);
         `CHK(img(wrows[i].a, wrows[i].r), wrows[i].d)
      end
      host.wr(adr(1'b0, 4'h7), 8'h40);
      `CHK({ext_b, wr_b[63:56]}, 16'h4000)
      host.wr(adr(1'b0, 4'hf), 8'h04);
      host.wr(adr(1'b0, 4'h7), 8'h77);
      `CHK({ext_b, wr_b[63:56], ext_a}, 24'h4077_00)
      foreach (rrows[i])
      begin
         host.rd(adr(rrows[i].a, rrows[i].r), got);
         `CHK(got, rrows[i].d)
      end
      host.wr(adr(1'b1, 4'h0), 8'h02);
      `CHK(hi, 1'b1)
      host.wr(adr(1'b0, 4'h0), 8'h02);
      mode_hi = 1'b0;
      `CHK(hi, 1'b0)
      host.wr(adr(1'b0, 4'h3), 8'h5a);
      host.wr(adr(1'b1, 4'h3), 8'h5a);
      `CHK({wr_a[31:24], wr_b[31:24]}, 16'h5a5a)
      host.rd(adr(1'b1, 4'h4), got);
      `CHK(got, 8'ha0)
      host.wr(adr(1'b0, 4'h0), 8'h01);
      mode_hi = 1'b1;
      `CHK(hi, 1'b1)
      host.wr(adr(1'b1, 4'h8), 8'h3c);
      `CHK(tx_seen, 9'h13c)
      host.rd(adr(1'b1, 4'h8), got);
      `CHK({got, rx_seen[7:0]}, 16'ha801)
      host.wr(adr(1'b0, 4'h9), 8'h80);
      `CHK({wr_a == 128'h0, wr_b[31:24]}, 9'h15a)
      host.wr(adr(1'b1, 4'h9), 8'hc0);
      `CHK({wr_b, vec, hi}, {128'h0, 8'h00, 1'b1})
      // pointer variant: command first, then the pointed access
      chan_sel = 1'b1;
      host2.rd(8'h00, got);
      `CHK(got, 8'ha0)
      chan_sel = 1'b0;
      host2.wr(8'h00, 8'h03);
      host2.wr(8'h00, 8'h5a);
      `CHK(wr_b2[31:24], 8'h5a)
      host2.wr(8'h00, 8'h0c);
      host2.rd(8'h00, got);
      `CHK({got, wr_b2[31:24]}, 16'hbc5a)
      host2.rd(8'h00, got);
      `CHK(got, 8'hb0)
      // data select must leave a pending pointer alone
      chan_sel = 1'b1;
      host2.wr(8'h00, 8'h01);
      fifo_sel = 1'b1;
      host2.wr(8'h00, 8'h3c);
      host2.rd(8'h00, got);
      `CHK({got, txd2, wr_a2[15:8]}, 24'ha8_3c00)
      fifo_sel = 1'b0;
      host2.rd(8'h00, got);
      `CHK(got, 8'ha1)
      // mid-run reset with a pointer pending
      host2.wr(8'h00, 8'h05);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      host2.rd(8'h00, got);
      `CHK(got, 8'ha0)
      conclude();
   end
endmodule
